// [core/scpr_pkg.sv]
package scpr_pkg;

  // ----------------------------------------------------------------
  // register byte addresses (aligned words on the register bus)
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_TOTAL_SECTORS = 6'h00;
  localparam logic [5:0] ADDR_TOTAL_HEADS = 6'h04;
  localparam logic [5:0] ADDR_CYL_TOTAL = 6'h08;
  localparam logic [5:0] ADDR_LOGICAL = 6'h0C;
  localparam logic [5:0] ADDR_SECTOR = 6'h10;
  localparam logic [5:0] ADDR_HEAD = 6'h14;
  localparam logic [5:0] ADDR_CYL_RESULT = 6'h18;
  localparam logic [5:0] ADDR_UNIT = 6'h1C;
  localparam logic [5:0] ADDR_PHASE = 6'h20;
  localparam logic [5:0] ADDR_SYNC = 6'h24;
  localparam logic [5:0] ADDR_LOCAL_ID = 6'h28;
  localparam logic [5:0] ADDR_STATUS = 6'h2C;

  // ----------------------------------------------------------------
  // field positions and masks
  // ----------------------------------------------------------------
  localparam int LUN_VALID_BIT = 7;
  localparam int DISC_OK_BIT = 6;
  localparam logic [7:0] UNIT_MASK = 8'hC7;
  localparam logic [7:0] PHASE_MASK = 8'h7F;
  localparam logic [7:0] SYNC_MASK = 8'h7F;
  localparam logic [7:0] LOCAL_ID_MASK = 8'hC0;
  localparam int PERIOD_LSB = 4;
  localparam logic [3:0] OFFSET_MAX = 4'hC;

  // ----------------------------------------------------------------
  // reset values and message codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] MSG_COMPLETE = 8'h00;
  localparam logic [7:0] MSG_LINKED = 8'h0A;
  localparam logic [7:0] MSG_LINKED_FLAG = 8'h0B;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // received cdb byte strobe and link-side events
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [3:0] index;
    logic [7:0] data;
  } scpr_cdb_byte_t;

  typedef struct packed {
    logic valid;
    logic [7:0] sector;
    logic [7:0] head;
    logic [15:0] cylinder;
  } scpr_xlate_result_t;

  typedef struct packed {
    logic [3:0] period;
    logic [2:0] strobe;
  } scpr_timing_t;

endpackage

// [core/scpr_regs.sv]
`timescale 1ns/10ps
module scpr_regs
  import scpr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sequencer side
  input wire scpr_cdb_byte_t rx_cdb,
  input wire scpr_xlate_result_t xlate_done,
  input wire logic identify_rx,
  input wire logic [2:0] identify_lun,
  input wire logic identify_disc_ok,
  input wire logic target_status_rx,
  input wire logic [7:0] target_status,
  input wire logic unexpected_resel,
  input wire logic [2:0] resel_lun,
  input wire logic phase_update,
  input wire logic [6:0] phase_value,
  input wire logic data_phase,
  output logic [7:0] reply_status_byte,
  output logic [7:0] completion_message,
  output logic [2:0] identify_unit,
  output logic compensate_spares,
  output logic sync_mode,
  output logic [3:0] fifo_depth,
  output logic [15:0] sectors_per_cyl,
  output logic xfer_clk_en,
  output logic req_ack_strobe
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] cdb_q [0:11];          // cdb bytes one to twelve
  logic [7:0] unit_number_identify_q; // lun plus flag bits
  logic [7:0] phase_progress_q;      // combination command progress
  logic [7:0] sync_offset_period_q;  // offset and period fields
  logic [7:0] local_id_config_q;     // divisor select bits 7:6
  logic [2:0] div_cnt_q;             // internal clock divider
  logic [3:0] per_cnt_q;             // period counter
  logic [3:0] period_cyc;
  logic [2:0] strobe_cyc;
  logic [2:0] div_max;

  // bus handshake state
  logic aw_hold_q;
  logic w_hold_q;
  logic [5:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic wr_hit;
  logic [7:0] wbyte;

  // ----------------------------------------------------------------
  // write channel: address and data taken in either order
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign wbyte = wdata_q[7:0];
  // only the low byte lane strobe enables a write; multi-byte words then take every lane
  assign wr_hit = wr_fire && wstrb_q[0];

  // capture address and data as each handshake completes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 6'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // write response, error on unmapped word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (awaddr_q > ADDR_STATUS || awaddr_q[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------------------------------
  // cdb byte array: bus writes and sequencer deposits
  // ----------------------------------------------------------------
  // word address to every cdb byte index covered by the parameter words
  function automatic logic wr_cdb(input logic [5:0] a, input int i);
    case (a)
      ADDR_TOTAL_SECTORS: wr_cdb = (i == 0);
      ADDR_TOTAL_HEADS: wr_cdb = (i == 1);
      ADDR_CYL_TOTAL: wr_cdb = (i == 2 || i == 3);
      ADDR_LOGICAL: wr_cdb = (i >= 4 && i <= 7);
      ADDR_SECTOR: wr_cdb = (i == 8);
      ADDR_HEAD: wr_cdb = (i == 9);
      ADDR_CYL_RESULT: wr_cdb = (i == 10 || i == 11);
      default: wr_cdb = 1'b0;
    endcase
  endfunction

  // byte lane within the written word for cdb byte i
  function automatic logic [7:0] lane(input logic [5:0] a, input logic [31:0] d, input int i);
    int sh;
    sh = 0;
    case (a)
      ADDR_CYL_TOTAL: sh = (i == 2) ? 8 : 0;
      ADDR_LOGICAL: sh = 8 * (7 - i);
      ADDR_CYL_RESULT: sh = (i == 10) ? 8 : 0;
      default: sh = 0;
    endcase
    lane = d[sh +: 8];
  endfunction

  // multi-byte words are big-endian: lowest cdb byte is most significant
  for (genvar i = 0; i < 12; i++) begin : g_cdb
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cdb_q[i] <= RESET_BYTE;
      end else if (rx_cdb.valid && rx_cdb.index == 4'(i)) begin
        // received byte deposited, later bytes only if the cdb has them
        cdb_q[i] <= rx_cdb.data;
      end else if (xlate_done.valid && i == 8) begin
        cdb_q[i] <= xlate_done.sector;
      end else if (xlate_done.valid && i == 9) begin
        cdb_q[i] <= xlate_done.head;
      end else if (xlate_done.valid && i == 10) begin
        cdb_q[i] <= xlate_done.cylinder[15:8];
      end else if (xlate_done.valid && i == 11) begin
        cdb_q[i] <= xlate_done.cylinder[7:0];
      end else if (wr_hit && wr_cdb(awaddr_q, i)) begin
        // host writes translate inputs or outgoing cdb bytes
        cdb_q[i] <= lane(awaddr_q, wdata_q, i);
      end
      // otherwise the byte holds its value
    end
  end

  // ----------------------------------------------------------------
  // unit number and identify flags
  // ----------------------------------------------------------------
  // hardware updates win over a same-cycle host write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_number_identify_q <= RESET_BYTE;
    end else if (unexpected_resel) begin
      unit_number_identify_q <= {2'b00, 3'b000, resel_lun};
    end else if (identify_rx) begin
      unit_number_identify_q <= {1'b1, identify_disc_ok, 3'b000, identify_lun};
    end else if (target_status_rx) begin
      unit_number_identify_q <= target_status;
    end else if (wr_hit && awaddr_q == ADDR_UNIT) begin
      unit_number_identify_q <= wbyte & UNIT_MASK;
    end
  end

  // ----------------------------------------------------------------
  // phase progress, sync timing, local id
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_progress_q <= RESET_BYTE;
    end else if (phase_update) begin
      phase_progress_q <= {1'b0, phase_value};
    end else if (wr_hit && awaddr_q == ADDR_PHASE) begin
      phase_progress_q <= wbyte & PHASE_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_offset_period_q <= RESET_BYTE;
    end else if (wr_hit && awaddr_q == ADDR_SYNC) begin
      sync_offset_period_q <= wbyte & SYNC_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      local_id_config_q <= RESET_BYTE;
    end else if (wr_hit && awaddr_q == ADDR_LOCAL_ID) begin
      local_id_config_q <= wbyte & LOCAL_ID_MASK;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_q;

  // read mux, one cycle after address taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_TOTAL_SECTORS: rdata_q <= {24'h000000, cdb_q[0]};
        ADDR_TOTAL_HEADS: rdata_q <= {24'h000000, cdb_q[1]};
        ADDR_CYL_TOTAL: rdata_q <= {16'h0000, cdb_q[2], cdb_q[3]};
        ADDR_LOGICAL: rdata_q <= {cdb_q[4], cdb_q[5], cdb_q[6], cdb_q[7]};
        ADDR_SECTOR: rdata_q <= {24'h000000, cdb_q[8]};
        ADDR_HEAD: rdata_q <= {24'h000000, cdb_q[9]};
        ADDR_CYL_RESULT: rdata_q <= {16'h0000, cdb_q[10], cdb_q[11]};
        ADDR_UNIT: rdata_q <= {24'h000000, unit_number_identify_q};
        ADDR_PHASE: rdata_q <= {24'h000000, phase_progress_q};
        ADDR_SYNC: rdata_q <= {24'h000000, sync_offset_period_q};
        ADDR_LOCAL_ID: rdata_q <= {24'h000000, local_id_config_q};
        ADDR_STATUS: rdata_q <= {27'h0000000, sync_mode, compensate_spares, fifo_depth == 4'h0,
                                 xfer_clk_en, req_ack_strobe};
        default: begin
          // unmapped word reads zero with an error
          rdata_q <= 32'h00000000;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------------------------------
  // command-side decodes
  // ----------------------------------------------------------------
  assign reply_status_byte = cdb_q[10];
  // linked messages pick flag form by bit 1
  assign completion_message = !cdb_q[11][0] ? MSG_COMPLETE :
                              (cdb_q[11][1] ? MSG_LINKED_FLAG : MSG_LINKED);
  assign identify_unit = unit_number_identify_q[2:0];
  // nonzero head byte is the spare count; limits are the host's job
  assign compensate_spares = (cdb_q[9] != RESET_BYTE);
  assign sectors_per_cyl = {cdb_q[10], cdb_q[11]};
  // undefined offsets 13-15 fall back to asynchronous
  assign fifo_depth = (sync_offset_period_q[3:0] > OFFSET_MAX) ? 4'h0 : sync_offset_period_q[3:0];
  assign sync_mode = data_phase && (fifo_depth != 4'h0);

  // period and strobe width in internal cycles
  always_comb begin
    period_cyc = 4'h8;
    strobe_cyc = 3'h4;
    unique case (sync_offset_period_q[PERIOD_LSB +: 3])
      3'h0, 3'h1: begin
        period_cyc = 4'h8;
        strobe_cyc = 3'h4;
      end
      3'h2: begin
        period_cyc = 4'h2;
        strobe_cyc = 3'h1;
      end
      3'h3: begin
        period_cyc = 4'h3;
        strobe_cyc = 3'h1;
      end
      3'h4: begin
        period_cyc = 4'h4;
        strobe_cyc = 3'h2;
      end
      3'h5: begin
        period_cyc = 4'h5;
        strobe_cyc = 3'h3;
      end
      3'h6: begin
        period_cyc = 4'h6;
        strobe_cyc = 3'h4;
      end
      3'h7: begin
        period_cyc = 4'h7;
        strobe_cyc = 3'h4;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // internal transfer clock divider and period generator
  // ----------------------------------------------------------------
  // divisor from local id bits 7:6: 00/01 -> 2, 10 -> 3, 11 -> 4
  assign div_max = local_id_config_q[7] ? (local_id_config_q[6] ? 3'h3 : 3'h2) : 3'h1;
  assign xfer_clk_en = (div_cnt_q == div_max);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q <= 3'h0;
    end else if (xfer_clk_en) begin
      div_cnt_q <= 3'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end

  // period counter ticks only on internal cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_cnt_q <= 4'h0;
    end else if (xfer_clk_en) begin
      per_cnt_q <= (per_cnt_q + 4'h1 >= period_cyc) ? 4'h0 : per_cnt_q + 4'h1;
    end
  end

  // strobe active for the first strobe_cyc of each period
  assign req_ack_strobe = (per_cnt_q < {1'b0, strobe_cyc});

endmodule

// [test/scpr_regs_chk.sv]
`timescale 1ns/10ps
// ------
// port checks of the parameter bank
// ------
module scpr_regs_chk
  import scpr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire scpr_cdb_byte_t rx_cdb,
  input wire scpr_xlate_result_t xlate_done,
  input wire logic identify_rx,
  input wire logic [2:0] identify_lun,
  input wire logic unexpected_resel,
  input wire logic [2:0] resel_lun,
  input wire logic data_phase,
  input wire logic [7:0] reply_status_byte,
  input wire logic [7:0] completion_message,
  input wire logic [2:0] identify_unit,
  input wire logic compensate_spares,
  input wire logic sync_mode,
  input wire logic [3:0] fifo_depth,
  input wire logic [15:0] sectors_per_cyl
);
  // one domain: one clock, one reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  msg_select_a: assert property (
    rx_cdb.valid && rx_cdb.index == 4'hB |=> completion_message == (!$past(rx_cdb.data[0]) ?
    MSG_COMPLETE : ($past(rx_cdb.data[1]) ? MSG_LINKED_FLAG : MSG_LINKED)))
    else $error("completion message wrong");
  status_byte_a: assert property (
    rx_cdb.valid && rx_cdb.index == 4'hA |=> reply_status_byte == $past(rx_cdb.data))
    else $error("status byte wrong");
  resel_lun_a: assert property (
    unexpected_resel |=> identify_unit == $past(resel_lun))
    else $error("reselect unit wrong");
  ident_lun_a: assert property (
    identify_rx && !unexpected_resel |=> identify_unit == $past(identify_lun))
    else $error("identify unit wrong");
  xlate_cyl_a: assert property (
    xlate_done.valid && !rx_cdb.valid |=> sectors_per_cyl == $past(xlate_done.cylinder))
    else $error("cylinder result wrong");
  spare_comp_a: assert property (
    xlate_done.valid && !rx_cdb.valid |=> compensate_spares == ($past(xlate_done.head) != 8'h00))
    else $error("compensation flag wrong");
  async_phase_a: assert property (
    sync_mode |-> data_phase && fifo_depth != 4'h0)
    else $error("sync outside data phase");
  offset_lim_a: assert property (
    fifo_depth <= OFFSET_MAX)
    else $error("fifo depth above twelve");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule

bind scpr_regs scpr_regs_chk i_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .rx_cdb, .xlate_done, .identify_rx, .identify_lun, .unexpected_resel, .resel_lun, .data_phase,
  .reply_status_byte, .completion_message, .identify_unit, .compensate_spares, .sync_mode,
  .fifo_depth, .sectors_per_cyl);

// [test/scpr_link_model.sv]
`timescale 1ns/10ps
// ------
// far side: bus sequencer events
// ------
module scpr_link_model
  import scpr_pkg::*;
(
  input wire logic aclk,
  output scpr_cdb_byte_t rx_cdb,
  output scpr_xlate_result_t xlate_done,
  output logic identify_rx,
  output logic [2:0] identify_lun,
  output logic identify_disc_ok,
  output logic target_status_rx,
  output logic [7:0] target_status,
  output logic unexpected_resel,
  output logic [2:0] resel_lun,
  output logic phase_update,
  output logic [6:0] phase_value,
  output logic data_phase
);
  initial begin
    {rx_cdb, xlate_done, identify_rx, identify_lun, identify_disc_ok, target_status_rx} = '0;
    {target_status, unexpected_resel, resel_lun, phase_update, phase_value, data_phase} = '0;
  end
  // idle data lines are inverted so stale values never match
  task automatic cdb(input logic [3:0] i, input logic [7:0] d);
    @(posedge aclk);
    rx_cdb <= '{1'b1, i, d};
    @(posedge aclk);
    rx_cdb <= '{1'b0, ~i, ~d};
  endtask
  // k: 0 identify, 1 reselect, 2 target status
  task automatic unit(input logic [1:0] k, input logic [7:0] v);
    @(posedge aclk);
    {identify_lun, resel_lun, target_status, identify_disc_ok} <= {v[2:0], v[2:0], v, v[6]};
    {identify_rx, unexpected_resel, target_status_rx} <= {k == 2'h0, k == 2'h1, k == 2'h2};
    @(posedge aclk);
    {identify_rx, unexpected_resel, target_status_rx} <= 3'h0;
    {identify_lun, resel_lun, target_status, identify_disc_ok} <= ~{v[2:0], v[2:0], v, v[6]};
  endtask
  // translate result: sector, head, cylinder
  task automatic xlate(input logic [31:0] v);
    @(posedge aclk);
    xlate_done <= {1'b1, v};
    @(posedge aclk);
    xlate_done <= {1'b0, ~v};
  endtask
  task automatic phase(input logic [6:0] v);
    @(posedge aclk);
    {phase_update, phase_value} <= {1'b1, v};
    @(posedge aclk);
    {phase_update, phase_value} <= {1'b0, ~v};
  endtask
  task automatic dp(input logic v);
    @(posedge aclk);
    data_phase <= v;
  endtask
endmodule

// [test/scpr_regs_bench.sv]
`timescale 1ns/10ps
module scpr_regs_bench;
  import scpr_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, fifo_depth;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  scpr_cdb_byte_t rx_cdb;
  scpr_xlate_result_t xlate_done;
  logic identify_rx, identify_disc_ok, target_status_rx, unexpected_resel, phase_update, data_phase;
  logic [2:0] identify_lun, resel_lun, identify_unit;
  logic [7:0] target_status, reply_status_byte, completion_message;
  logic [6:0] phase_value;
  logic compensate_spares, sync_mode, xfer_clk_en, req_ack_strobe;
  logic [15:0] sectors_per_cyl;
  logic [33:0] note;
  logic [33:0] expq [$]; // read notes: {resp, data}
  int n_mismatch, tests_run, cyc, seed;
  scpr_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_cdb,
    .xlate_done, .identify_rx, .identify_lun, .identify_disc_ok, .target_status_rx, .target_status,
    .unexpected_resel, .resel_lun, .phase_update, .phase_value, .data_phase, .reply_status_byte,
    .completion_message, .identify_unit, .compensate_spares, .sync_mode, .fifo_depth, .sectors_per_cyl,
    .xfer_clk_en, .req_ack_strobe);
  scpr_link_model i_link (.aclk, .rx_cdb, .xlate_done, .identify_rx, .identify_lun, .identify_disc_ok,
    .target_status_rx, .target_status, .unexpected_resel, .resel_lun, .phase_update, .phase_value, .data_phase);
  // ------
  // helpers
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // address and data offered together, each dropped when taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    logic ap, wp;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    ap = 1'b1;
    wp = 1'b1;
    do begin
      @(posedge aclk);
      if (ap && s_axi_awready === 1'b1) begin
        ap = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wp && s_axi_wready === 1'b1) begin
        wp = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(e), "bresp");
  endtask
  // read: expectation noted, monitor compares
  task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    expq.push_back({e, d});
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      note = expq.pop_front();
      check(s_axi_rdata, note[31:0], "rdata");
      check(32'(s_axi_rresp), 32'(note[33:32]), "rresp");
    end
  end
  // hang guard, far above the expected run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ------
  // main sequence
  // ------
  initial begin
    logic [7:0] c [12];
    logic [31:0] v;
    int hi, per, xe, dv;
    int p [8] = '{8, 8, 2, 3, 4, 5, 6, 7};
    int w [8] = '{4, 4, 1, 1, 2, 3, 4, 4};
    logic [31:0] mk [11] = '{32'hFF, 32'hFF, 32'hFFFF, 32'hFFFFFFFF, 32'hFF, 32'hFF, 32'hFFFF, 32'hC7,
      32'h7F, 32'h7F, 32'hC0};
    {seed, n_mismatch, tests_run, cyc} = {32'd79712, 96'h0};
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 11; i++)
      rd(6'(4 * i), 32'h0, RESP_OKAY);
    rd(6'h30, 32'h0, RESP_SLVERR);
    rd(6'h02, 32'h0, RESP_SLVERR);
    wr(6'h30, 32'h1, 4'hF, RESP_SLVERR);
    // readback with reserved bits masked
    for (int i = 0; i < 11; i++) begin
      v = $random(seed);
      wr(6'(4 * i), v, 4'hF, RESP_OKAY);
      rd(6'(4 * i), v & mk[i], RESP_OKAY);
    end
    wr(ADDR_SECTOR, 32'h3C, 4'hF, RESP_OKAY);
    wr(ADDR_SECTOR, 32'hC3, 4'hE, RESP_OKAY);
    rd(ADDR_SECTOR, 32'h3C, RESP_OKAY);
    // second reset in mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_SECTOR, 32'h0, RESP_OKAY);
    // full twelve-byte received command
    for (int i = 0; i < 12; i++) begin
      c[i] = 8'($random(seed));
      i_link.cdb(4'(i), c[i]);
    end
    rd(ADDR_TOTAL_SECTORS, {24'h0, c[0]}, RESP_OKAY);
    rd(ADDR_TOTAL_HEADS, {24'h0, c[1]}, RESP_OKAY);
    rd(ADDR_CYL_TOTAL, {16'h0, c[2], c[3]}, RESP_OKAY);
    rd(ADDR_LOGICAL, {c[4], c[5], c[6], c[7]}, RESP_OKAY);
    rd(ADDR_SECTOR, {24'h0, c[8]}, RESP_OKAY);
    rd(ADDR_HEAD, {24'h0, c[9]}, RESP_OKAY);
    rd(ADDR_CYL_RESULT, {16'h0, c[10], c[11]}, RESP_OKAY);
    check(32'(reply_status_byte), 32'(c[10]), "status byte");
    for (int k = 0; k < 4; k++) begin
      i_link.cdb(4'hB, 8'(($random(seed) & 32'hFC) | k));
      @(negedge aclk);
      check(32'(completion_message), k[0] ? (k[1] ? 32'h0B : 32'h0A) : 32'h00, "message");
    end
    // unit register events
    i_link.unit(2'h0, 8'h45);
    rd(ADDR_UNIT, 32'hC5, RESP_OKAY);
    check(32'(identify_unit), 32'h5, "identify unit");
    // identify without disconnect permission keeps that flag low
    i_link.unit(2'h0, 8'h02);
    rd(ADDR_UNIT, 32'h82, RESP_OKAY);
    i_link.unit(2'h1, 8'hC3);
    rd(ADDR_UNIT, 32'h03, RESP_OKAY);
    v = $random(seed);
    i_link.unit(2'h2, v[7:0]);
    rd(ADDR_UNIT, {24'h0, v[7:0]}, RESP_OKAY);
    // translate results
    v = $random(seed);
    i_link.xlate(v);
    rd(ADDR_SECTOR, {24'h0, v[31:24]}, RESP_OKAY);
    rd(ADDR_HEAD, {24'h0, v[23:16]}, RESP_OKAY);
    rd(ADDR_CYL_RESULT, {16'h0, v[15:0]}, RESP_OKAY);
    check(32'(sectors_per_cyl), {16'h0, v[15:0]}, "sectors per cylinder");
    check(32'(compensate_spares), 32'(v[23:16] != 8'h00), "compensate");
    wr(ADDR_HEAD, 32'h0, 4'hF, RESP_OKAY);
    check(32'(compensate_spares), 32'h0, "no compensate");
    // six-byte command: host fills only cdb bytes five and six
    wr(ADDR_LOGICAL, {v[15:0], 16'h0}, 4'hF, RESP_OKAY);
    rd(ADDR_LOGICAL, {v[15:0], 16'h0}, RESP_OKAY);
    // logical block address loaded ahead of a translate
    wr(ADDR_LOGICAL, v, 4'hF, RESP_OKAY);
    rd(ADDR_LOGICAL, v, RESP_OKAY);
    // compensated geometry inside the limits: 4096 cylinders, 15 heads
    wr(ADDR_TOTAL_SECTORS, 32'h11, 4'hF, RESP_OKAY);
    wr(ADDR_TOTAL_HEADS, 32'hF, 4'hF, RESP_OKAY);
    wr(ADDR_CYL_TOTAL, 32'h1000, 4'hF, RESP_OKAY);
    rd(ADDR_CYL_TOTAL, 32'h1000, RESP_OKAY);
    wr(ADDR_HEAD, 32'h3, 4'hF, RESP_OKAY);
    check(32'(compensate_spares), 32'h1, "compensate on");
    // sectors per cylinder preloaded: 17 * 15 - 3
    wr(ADDR_CYL_RESULT, 32'd252, 4'hF, RESP_OKAY);
    check(32'(sectors_per_cyl), 32'd252, "sectors per cylinder");
    i_link.phase(7'h5A);
    rd(ADDR_PHASE, 32'h5A, RESP_OKAY);
    // every offset in and out of a data phase
    for (int o = 0; o < 32; o++) begin
      i_link.dp(o[4]);
      wr(ADDR_SYNC, 32'(o[3:0]), 4'hF, RESP_OKAY);
      @(negedge aclk);
      v = (o[3:0] >= 1 && o[3:0] <= 12) ? 32'(o[3:0]) : 32'h0;
      check(32'(fifo_depth), v, "fifo depth");
      check(32'(sync_mode), 32'(o[4] && v != 0), "sync mode");
    end
    // every period code, then other divisors
    for (int t = 0; t < 10; t++) begin
      dv = t < 8 ? 2 : (t == 8 ? 3 : 4);
      wr(ADDR_LOCAL_ID, t < 8 ? 32'h0 : (t == 8 ? 32'h80 : 32'hC0), 4'hF, RESP_OKAY);
      wr(ADDR_SYNC, 32'((t % 8) << PERIOD_LSB), 4'hF, RESP_OKAY);
      while (req_ack_strobe !== 1'b0) @(posedge aclk);
      while (req_ack_strobe !== 1'b1) @(posedge aclk);
      {hi, per, xe} = '0;
      while (req_ack_strobe === 1'b1) begin
        hi++;
        xe += int'(xfer_clk_en);
        @(posedge aclk);
      end
      while (req_ack_strobe === 1'b0) begin
        per++;
        xe += int'(xfer_clk_en);
        @(posedge aclk);
      end
      check(hi, w[t % 8] * dv, "strobe width");
      check(hi + per, p[t % 8] * dv, "period");
      check(xe, p[t % 8], "internal cycles");
    end
    report_and_stop();
  end
endmodule
